// *** rtl/tpc_regs.svh ***
`ifndef TPC_REGS_SVH
`define TPC_REGS_SVH

// Fixed divider ratios and the counter widths of all three dividers
`define TPC_REF_RATIO       10'h200
`define TPC_REF_WIDTH       10
`define TPC_PRESCALE_RATIO  4'h8
`define TPC_PRESCALE_WIDTH  4
`define TPC_DIV_WIDTH       15

// Address byte
`define TPC_ADDR_FIXED      5'h18
`define TPC_ADDR_DIR_WRITE  1'b0

// Byte type flag and serial framing
`define TPC_TYPE_BIT        7
`define TPC_BITS_PER_BYTE   4'h8

// Control byte one fields
`define TPC_LC_CURRENT_HIGH 6
`define TPC_LC_TEST_ROUTE   5
`define TPC_LC_TRISTATE     4
`define TPC_LC_AMP_OFF      0

// Control byte two fields
`define TPC_PC_PORT_LSB     4
`define TPC_PC_PORT_MSB     7
`define TPC_PC_BAND_LSB     0
`define TPC_PC_BAND_MSB     2

// Register reset values
`define TPC_DIV_UPPER_RST   8'h00
`define TPC_DIV_LOWER_RST   8'h00
`define TPC_LOOP_CTL_RST    8'h00
`define TPC_PORT_CTL_RST    8'h00

`endif

// *** rtl/tpc_pkg.sv ***
package tpc_pkg;

    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_ACK,
        I2C_DATA,
        I2C_IGNORE
    } tpc_i2c_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } tpc_i2c_in_t;

    typedef struct packed {
        logic drive;
        logic oe;
        logic currentHigh;
    } tpc_pump_t;

endpackage : tpc_pkg

// *** rtl/tpc_divider.sv ***
`timescale 1ns/100ps
`include "tpc_regs.svh"

module tpc_divider #(
    parameter int WIDTH = `TPC_DIV_WIDTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rstn,
    input  wire logic             ce,
    input  wire logic             tick,
    input  wire logic [WIDTH-1:0] ratio,
    output logic                  divOut,
    output logic                  wrap
);
    import tpc_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             out;
        logic             wrap;
    } tpc_div_state_t;

    tpc_div_state_t q;
    tpc_div_state_t d;

    // Output falls on the wrap, so the wrap pulse marks the falling edge
    always_comb begin
        d = q;
        d.wrap = 1'b0;
        if (tick) begin
            if (q.cnt >= ratio - WIDTH'(1)) begin
                d.cnt = '0;
                d.wrap = 1'b1;
            end else begin
                d.cnt = q.cnt + WIDTH'(1);
            end
        end
        d.out = (d.cnt >= (ratio >> 1));
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign divOut = q.out;
    assign wrap   = q.wrap;

    property p_div_wrap;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && tick && q.cnt == ratio - WIDTH'(1)) |=> (q.wrap && q.cnt == '0);
    endproperty
    a_div_wrap: assert property (p_div_wrap) else $error("divider missed its wrap");

endmodule : tpc_divider

// *** rtl/tpc_phase_det.sv ***
`timescale 1ns/100ps

module tpc_phase_det (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic ce,
    input  wire logic divFall,
    input  wire logic refFall,
    output logic      up,
    output logic      dn
);
    import tpc_pkg::*;

    typedef struct packed {
        logic up;
        logic dn;
    } tpc_pfd_state_t;

    tpc_pfd_state_t q;
    tpc_pfd_state_t d;

    // Edges that meet in one cycle cancel: no pulse while in phase
    always_comb begin
        d = q;
        d.up = q.up | divFall;
        d.dn = q.dn | refFall;
        if (d.up && d.dn) begin
            d.up = 1'b0;
            d.dn = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    assign up = q.up;
    assign dn = q.dn;

    property p_never_both;
        @(posedge clk_sys) disable iff (!rstn)
        !(q.up && q.dn);
    endproperty
    a_never_both: assert property (p_never_both) else $error("up and down both on");

    property p_up_on_div;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && divFall && !refFall && !q.dn) |=> (q.up && !q.dn);
    endproperty
    a_up_on_div: assert property (p_up_on_div) else $error("early vco edge gave no up");

endmodule : tpc_phase_det

// *** rtl/tpc_top.sv ***
// What this block does
// - Reference is the device clock divided by a fixed 512.
// - Input goes through divide-by-8, then programmable divider 256 to 32767.
// - Up pulses when divided input falls first; down pulses otherwise.
// - In phase, neither pump current is driven; output floats.
// - Tristate bit at 1 floats the pump output whatever the detector does.
// - Amplifier-off bit at 1 disconnects the tuning amplifier output.
// - Pump current select bit at 1 picks the high current, else low.
// - Band bit at 1 turns its band output on; 0 leaves it off.
// - Each of four port bits at 1 turns its port output on.
// - Test bit routes reference to port six, divided input to port seven.
// - Start is SDA falling with SCL high; stop is SDA rising; both detected.
// - SDA changes only while SCL low; bits are sampled on SCL rise.
// - Device pulls SDA low through the ninth clock as acknowledge.
// - Address byte is 11000, two chip-select bits, then a low direction bit.
// - First or third data byte MSB: 0 means divider pair, 1 control pair.
// - Second byte of a pair has the first byte's type, or a stop comes.
// - Divider ratio is 15 bits: upper seven from byte one, lower eight from two.
// - Control byte one: flag, current select, test, tristate, three ones, amp-off.
// - Control byte two: ports seven to four, spare bit, bands two to zero.
// - Chip-select bits come from the coded level on the address-select pin.
// - After power-up reset the device leaves SDA released until it acknowledges.
`timescale 1ns/100ps
`include "tpc_regs.svh"

module tpc_top (
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic              ce,
    input  wire tpc_pkg::tpc_i2c_in_t i2cIn,
    output logic                   sdaOut,
    output logic                   sdaOe,
    input  wire logic [1:0]        addrSelLevel,
    input  wire logic              vcoIn,
    output tpc_pkg::tpc_pump_t     pumpOut,
    output logic                   tuningAmpOn,
    output logic [2:0]             bandOn,
    output logic [3:0]             portOn
);
    import tpc_pkg::*;

    typedef struct packed {
        tpc_i2c_state_t state;
        logic           sclPrev;
        logic           sdaPrev;
        logic           vcoPrev;
        logic [3:0]     bitCnt;
        logic [7:0]     shift;
        logic           ackOn;
        logic           addressed;
        logic           secondExp;
        logic           pendCtl;
        logic [7:0]     divUpper;
        logic [7:0]     divLower;
        logic [7:0]     loopCtl;
        logic [7:0]     portCtl;
        logic [1:0]     chipSel;
        logic           csTaken;
        tpc_pump_t      pump;
        logic           ampOn;
        logic [2:0]     band;
        logic [3:0]     port;
    } tpc_top_state_t;

    tpc_top_state_t q;
    tpc_top_state_t d;

    logic        sclRise;
    logic        sclFall;
    logic        startCond;
    logic        stopCond;
    logic        byteDone;
    logic        addrMatch;
    logic        vcoRise;
    logic        preWrap;
    logic        refClk;
    logic        refWrap;
    logic        divClk;
    logic        divWrap;
    logic        pfdUp;
    logic        pfdDn;
    logic [14:0] divRatio;

    assign sclRise   = i2cIn.scl && !q.sclPrev;
    assign sclFall   = !i2cIn.scl && q.sclPrev;
    assign startCond = i2cIn.scl && q.sclPrev && q.sdaPrev && !i2cIn.sda;
    assign stopCond  = i2cIn.scl && q.sclPrev && !q.sdaPrev && i2cIn.sda;
    assign byteDone  = sclFall && (q.bitCnt == `TPC_BITS_PER_BYTE);
    assign addrMatch = (q.shift == {`TPC_ADDR_FIXED, q.chipSel, `TPC_ADDR_DIR_WRITE});
    assign vcoRise   = vcoIn && !q.vcoPrev;
    assign divRatio  = {q.divUpper[6:0], q.divLower};

    // Reference runs off the device clock, gated only by ce
    tpc_divider #(
        .WIDTH (`TPC_REF_WIDTH)
    ) u_ref_div (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .tick    (1'b1),
        .ratio   (`TPC_REF_RATIO),
        .divOut  (refClk),
        .wrap    (refWrap)
    );

    tpc_divider #(
        .WIDTH (`TPC_PRESCALE_WIDTH)
    ) u_prescale (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .tick    (vcoRise),
        .ratio   (`TPC_PRESCALE_RATIO),
        .divOut  (),
        .wrap    (preWrap)
    );

    // A ratio below the documented floor still divides, just not usefully
    tpc_divider #(
        .WIDTH (`TPC_DIV_WIDTH)
    ) u_prog_div (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .tick    (preWrap),
        .ratio   (divRatio),
        .divOut  (divClk),
        .wrap    (divWrap)
    );

    tpc_phase_det u_pfd (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .divFall (divWrap),
        .refFall (refWrap),
        .up      (pfdUp),
        .dn      (pfdDn)
    );

    always_comb begin
        d = q;
        d.sclPrev = i2cIn.scl;
        d.sdaPrev = i2cIn.sda;
        d.vcoPrev = vcoIn;

        // Strap is caught once, on the first enabled cycle after reset
        if (!q.csTaken) begin
            d.chipSel = addrSelLevel;
            d.csTaken = 1'b1;
        end

        case (q.state)
            I2C_ADDR, I2C_DATA: begin
                if (sclRise) begin
                    d.shift  = {q.shift[6:0], i2cIn.sda};
                    d.bitCnt = q.bitCnt + 4'h1;
                end
                if (byteDone) begin
                    d.bitCnt = 4'h0;
                    if (q.state == I2C_ADDR) begin
                        if (addrMatch) begin
                            d.addressed = 1'b1;
                            d.ackOn     = 1'b1;
                            d.state     = I2C_ACK;
                        end else begin
                            d.state = I2C_IGNORE;
                        end
                    end else begin
                        d.ackOn = 1'b1;
                        d.state = I2C_ACK;
                        if (!q.secondExp) begin
                            d.secondExp = 1'b1;
                            if (q.shift[`TPC_TYPE_BIT]) begin
                                d.loopCtl = q.shift;
                                d.pendCtl = 1'b1;
                            end else begin
                                d.divUpper = q.shift;
                                d.pendCtl  = 1'b0;
                            end
                        end else begin
                            // Master keeps the pair's type; no type check here
                            d.secondExp = 1'b0;
                            if (q.pendCtl) begin
                                d.portCtl = q.shift;
                            end else begin
                                d.divLower = q.shift;
                            end
                        end
                    end
                end
            end
            I2C_ACK: begin
                if (sclFall) begin
                    d.ackOn = 1'b0;
                    d.state = I2C_DATA;
                end
            end
            I2C_IDLE, I2C_IGNORE: begin
                d.ackOn = 1'b0;
            end
            default: begin
                d.ackOn = 1'b0;
                d.state = I2C_IDLE;
            end
        endcase

        // Bus conditions override whatever the byte machine decided
        if (startCond) begin
            d.state     = I2C_ADDR;
            d.bitCnt    = 4'h0;
            d.ackOn     = 1'b0;
            d.addressed = 1'b0;
            d.secondExp = 1'b0;
        end else if (stopCond) begin
            d.state     = I2C_IDLE;
            d.ackOn     = 1'b0;
            d.addressed = 1'b0;
        end

        // Pump drives only while exactly one detector pulse is on
        d.pump.drive       = pfdUp;
        d.pump.oe          = (pfdUp ^ pfdDn) && !q.loopCtl[`TPC_LC_TRISTATE];
        d.pump.currentHigh = q.loopCtl[`TPC_LC_CURRENT_HIGH];
        d.ampOn            = !q.loopCtl[`TPC_LC_AMP_OFF];
        d.band             = q.portCtl[`TPC_PC_BAND_MSB:`TPC_PC_BAND_LSB];
        d.port             = q.portCtl[`TPC_PC_PORT_MSB:`TPC_PC_PORT_LSB];
        if (q.loopCtl[`TPC_LC_TEST_ROUTE]) begin
            d.port[2] = refClk;
            d.port[3] = divClk;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q          <= '0;
            q.state    <= I2C_IDLE;
            q.sclPrev  <= 1'b1;
            q.sdaPrev  <= 1'b1;
            q.ackOn    <= 1'b0;
            q.divUpper <= `TPC_DIV_UPPER_RST;
            q.divLower <= `TPC_DIV_LOWER_RST;
            q.loopCtl  <= `TPC_LOOP_CTL_RST;
            q.portCtl  <= `TPC_PORT_CTL_RST;
        end else if (ce) begin
            q <= d;
        end
    end

    // SDA is only ever pulled low; the level itself never varies
    assign sdaOut      = 1'b0;
    assign sdaOe       = q.ackOn;
    assign pumpOut     = q.pump;
    assign tuningAmpOn = q.ampOn;
    assign bandOn      = q.band;
    assign portOn      = q.port;

    property p_ack_cause;
        @(posedge clk_sys) disable iff (!rstn)
        $rose(sdaOe) |-> $past(byteDone);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without a full byte");

    property p_ack_release;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && sdaOe && sclFall && !startCond && !stopCond) |=> !sdaOe;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("ack held past ninth clock");

    property p_reset_quiet;
        @(posedge clk_sys)
        $rose(rstn) |-> !sdaOe;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("SDA pulled at reset release");

    property p_ignore_quiet;
        @(posedge clk_sys) disable iff (!rstn)
        (q.state == I2C_IGNORE) |-> !sdaOe;
    endproperty
    a_ignore_quiet: assert property (p_ignore_quiet) else $error("acked foreign address");

    property p_addr_match;
        @(posedge clk_sys) disable iff (!rstn)
        $rose(q.addressed) |-> ($past(q.shift) == {`TPC_ADDR_FIXED, q.chipSel, 1'b0});
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("wrong address accepted");

    property p_start_seen;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && startCond) |=> (q.state == I2C_ADDR && q.bitCnt == 4'h0);
    endproperty
    a_start_seen: assert property (p_start_seen) else $error("start not detected");

    property p_sample_rise;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && sclRise && !startCond && (q.state == I2C_DATA || q.state == I2C_ADDR))
            |=> (q.shift[0] == $past(i2cIn.sda));
    endproperty
    a_sample_rise: assert property (p_sample_rise) else $error("bit not sampled on rise");

    property p_div_pair;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && byteDone && q.state == I2C_DATA && q.secondExp && !q.pendCtl && !startCond)
            |=> (q.divLower == $past(q.shift) && !q.secondExp);
    endproperty
    a_div_pair: assert property (p_div_pair) else $error("divider second byte lost");

    property p_tristate;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && q.loopCtl[`TPC_LC_TRISTATE]) |=> !pumpOut.oe;
    endproperty
    a_tristate: assert property (p_tristate) else $error("pump driven while tristated");

    property p_current;
        @(posedge clk_sys) disable iff (!rstn)
        ce |=> (pumpOut.currentHigh == $past(q.loopCtl[`TPC_LC_CURRENT_HIGH]));
    endproperty
    a_current: assert property (p_current) else $error("pump current not following");

    property p_amp_off;
        @(posedge clk_sys) disable iff (!rstn)
        ce |=> (tuningAmpOn == !$past(q.loopCtl[`TPC_LC_AMP_OFF]));
    endproperty
    a_amp_off: assert property (p_amp_off) else $error("amplifier not following");

    property p_band;
        @(posedge clk_sys) disable iff (!rstn)
        ce |=> (bandOn == $past(q.portCtl[2:0]));
    endproperty
    a_band: assert property (p_band) else $error("band outputs not following");

    property p_test_route;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && q.loopCtl[`TPC_LC_TEST_ROUTE]) |=> (portOn[2] == $past(refClk)
            && portOn[3] == $past(divClk));
    endproperty
    a_test_route: assert property (p_test_route) else $error("test signals not routed");

    property p_lock_quiet;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && !pfdUp && !pfdDn) |=> !pumpOut.oe;
    endproperty
    a_lock_quiet: assert property (p_lock_quiet) else $error("pump driven while in phase");

    c_ack: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(sdaOe));
    c_div_pair: cover property (@(posedge clk_sys) disable iff (!rstn)
        $changed(q.divLower));
    c_ctl_pair: cover property (@(posedge clk_sys) disable iff (!rstn)
        $changed(q.portCtl));
    c_test_mode: cover property (@(posedge clk_sys) disable iff (!rstn)
        q.loopCtl[`TPC_LC_TEST_ROUTE]);

endmodule : tpc_top

// *** bench/tpc_i2c_master.sv ***
`timescale 1ns/100ps

module tpc_i2c_master (
    input  wire logic            clk_sys,
    input  wire logic            sdaOut,
    input  wire logic            sdaOe,
    output tpc_pkg::tpc_i2c_in_t i2cIn
);
    import tpc_pkg::*;

    logic sclQ = 1'b1;
    logic pullQ = 1'b0;

    // Pull-up on the data wire: it is low while either side pulls it
    assign i2cIn = {sclQ, ~pullQ & ~(sdaOe & ~sdaOut)};

    task automatic half();
        repeat (4) @(posedge clk_sys);
    endtask : half

    // Data is released before the clock rises, so a repeated start is clean
    task automatic start();
        pullQ <= 1'b0;
        half();
        sclQ <= 1'b1;
        half();
        pullQ <= 1'b1;
        half();
        sclQ <= 1'b0;
        half();
    endtask : start

    task automatic stop();
        pullQ <= 1'b1;
        half();
        sclQ <= 1'b1;
        half();
        pullQ <= 1'b0;
        half();
    endtask : stop

    // Ninth pulse with data released; acknowledge read while the clock is high
    task automatic writeByte(input logic [7:0] b, output logic ack);
        int i;
        for (i = 8; i >= 0; i--) begin
            pullQ <= (i > 0) ? ~b[i-1] : 1'b0;
            half();
            sclQ <= 1'b1;
            half();
            ack = ~i2cIn.sda;
            sclQ <= 1'b0;
            half();
        end
    endtask : writeByte
endmodule : tpc_i2c_master

// *** bench/tb_top.sv ***
`timescale 1ns/100ps

module tb_top;
    import tpc_pkg::*;

    logic        clk_sys = 1'b0;
    logic        rstn;
    logic        ce;
    tpc_i2c_in_t i2cIn;
    logic        sdaOe;
    logic        sdaOut;
    logic [1:0]  addrSelLevel;
    logic        vcoIn = 1'b0;
    tpc_pump_t   pumpOut;
    logic        tuningAmpOn;
    logic [2:0]  bandOn;
    logic [3:0]  portOn;
    logic [15:0] lfsr = 16'h0039;
    logic [7:0]  adr;
    int          errorCnt = 0;
    int          compares = 0;

    always #10 clk_sys = ~clk_sys;
    // One input rising edge every two clocks
    always @(posedge clk_sys) vcoIn <= ~vcoIn;

    tpc_top DUT (
        .clk_sys      (clk_sys),
        .rstn         (rstn),
        .ce           (ce),
        .i2cIn        (i2cIn),
        .sdaOut       (sdaOut),
        .sdaOe        (sdaOe),
        .addrSelLevel (addrSelLevel),
        .vcoIn        (vcoIn),
        .pumpOut      (pumpOut),
        .tuningAmpOn  (tuningAmpOn),
        .bandOn       (bandOn),
        .portOn       (portOn)
    );

    tpc_i2c_master mst (.clk_sys(clk_sys), .sdaOut(sdaOut), .sdaOe(sdaOe), .i2cIn(i2cIn));

    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsrNext

    function automatic int divPeriod(input int n);
        return 2 * 8 * n;
    endfunction : divPeriod

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            errorCnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic tele(input logic [39:0] bytes, input int n, input logic expAck);
        logic ack;
        int   i;
        mst.start();
        for (i = 0; i < n; i++) begin
            mst.writeByte(bytes[39-8*i -: 8], ack);
            check("ack", {15'h0000, expAck}, {15'h0000, ack});
        end
        mst.stop();
        repeat (4) @(posedge clk_sys);
    endtask : tele

    // Time between the second and third rising edge of one port output
    task automatic period(input int idx, output int cyc);
        int   n;
        int   t0;
        int   rises;
        logic prev;
        rises = 0;
        t0 = 0;
        cyc = 0;
        prev = portOn[idx];
        for (n = 0; n < 30000 && rises < 3; n++) begin
            @(posedge clk_sys);
            #1;
            if (portOn[idx] === 1'b1 && prev === 1'b0) begin
                rises++;
                if (rises == 2) t0 = n;
                if (rises == 3) cyc = n - t0;
            end
            prev = portOn[idx];
        end
    endtask : period

    task automatic pumpWatch(input int len, output int hi, output int lo, output int up);
        hi = 0;
        lo = 0;
        up = 0;
        repeat (len) begin
            @(posedge clk_sys);
            #1;
            if (pumpOut.oe === 1'b1) hi++;
            if (pumpOut.oe === 1'b0) lo++;
            if (pumpOut.oe === 1'b1 && pumpOut.drive !== 1'b0) up++;
        end
    endtask : pumpWatch

    task automatic testDone();
        $display("compares %0d mismatches %0d", compares, errorCnt);
        if (errorCnt == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : testDone

    initial begin
        logic [15:0] r;
        logic [7:0]  b;
        logic [7:0]  lower;
        logic [3:0]  v;
        int          c;
        int          hi;
        int          lo;
        int          up;
        int          k;
        rstn = 1'b0;
        ce = 1'b1;
        lfsr = lfsrNext(lfsr);
        addrSelLevel = lfsr[1:0];
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        check("sdaOe", 16'h0000, {15'h0000, sdaOe});
        check("outputs", 16'h0000, {6'h00, bandOn, portOn, pumpOut});
        $display("test reset done");
        // Every chip address plus a read: only the strapped write address is taken
        adr = {5'h18, addrSelLevel, 1'b0};
        r = 16'h0000;
        for (k = 0; k < 5; k++) begin
            v = 4'(k + 1);
            b = (k < 4) ? {5'h18, k[1:0], 1'b0} : {adr[7:1], 1'b1};
            tele({b, 8'h8E, v, 1'b0, v[2:0], 16'h0000}, 3, k == addrSelLevel);
            if (k == addrSelLevel) r = {8'h00, v, 1'b0, v[2:0]};
            check("portOn", {12'h000, r[7:4]}, {12'h000, portOn});
            check("bandOn", {13'h0000, r[2:0]}, {13'h0000, bandOn});
        end
        $display("test address done");
        lfsr = lfsrNext(lfsr);
        lower = {2'b00, lfsr[5:0]};
        tele({adr, 8'h01, lower, 8'hAE, 8'h03}, 5, 1'b1);
        check("bandOn", 16'h0003, {13'h0000, bandOn});
        period(2, c);
        check("refPeriod", 16'h0200, 16'(c));
        period(3, c);
        check("divPeriod", 16'(divPeriod(256 + lower)), 16'(c));
        // Upper divider byte alone, closed by a stop
        tele({adr, 8'h02, 24'h000000}, 2, 1'b1);
        period(3, c);
        check("divPeriod", 16'(divPeriod(512 + lower)), 16'(c));
        $display("test divider done");
        for (k = 0; k < 4; k++) begin
            lfsr = lfsrNext(lfsr);
            r = lfsr;
            // Corner patterns on top of the random word flip the port nibble, amp-off and current bits
            r = r ^ {(k[0] ? 4'hA : 4'h5), 9'h000, k[1], 1'b0, k[1]};
            b = {1'b1, r[0], 1'b0, k[0], 3'b111, r[2]};
            tele({adr, b, r[15:8], 16'h0000}, 3, 1'b1);
            check("bandOn", {13'h0000, r[10:8]}, {13'h0000, bandOn});
            check("portOn", {12'h000, r[15:12]}, {12'h000, portOn});
            check("ampOn", {15'h0000, ~r[2]}, {15'h0000, tuningAmpOn});
            check("current", {15'h0000, r[0]}, {15'h0000, pumpOut.currentHigh});
            // The 10000-cycle window spans a full divided period so lock gaps must show
            pumpWatch(k[0] ? 2000 : 10000, hi, lo, up);
            if (k[0]) begin
                check("pumpOn", 16'h0000, 16'(hi));
            end else begin
                check("pumpDown", 16'h0001, 16'(hi > 0));
                check("pumpUp", 16'h0000, 16'(up));
                check("pumpOff", 16'h0001, 16'(lo > 0));
            end
        end
        $display("test control done");
        // A frozen device must neither answer nor take the bytes
        @(posedge clk_sys);
        ce <= 1'b0;
        tele({adr, 8'h8E, 8'hF7, 16'h0000}, 3, 1'b0);
        ce <= 1'b1;
        #1;
        check("bandOn", {13'h0000, r[10:8]}, {13'h0000, bandOn});
        check("portOn", {12'h000, r[15:12]}, {12'h000, portOn});
        $display("test enable done");
        testDone();
    end

    // Tests take some 62000 cycles
    initial begin
        repeat (95000) @(posedge clk_sys);
        errorCnt++;
        testDone();
    end
endmodule : tb_top
